// ### strap_cfg_defs.vh
// Constants for the strap capture and serial role block
`ifndef STRAP_CFG_DEFS_VH
`define STRAP_CFG_DEFS_VH
`define SCFG_ROLE_I2C 2'h0
`define SCFG_ROLE_RSVD 2'h1
`define SCFG_ROLE_SPI 2'h2
`define SCFG_ROLE_BIST 2'h3
`define SCFG_CLK_HZ 40000000
`define SCFG_I2C_HZ 81000
// Half period of the I2C clock, rounded down: 40e6 / (2 * 81e3) = 246
`define SCFG_I2C_HALF (`SCFG_CLK_HZ / (2 * `SCFG_I2C_HZ))
`define SCFG_EE_ADDR 8'ha1
`define SCFG_TO_CYC 16'hffff
`define SCFG_ST_IDLE 3'h0
`define SCFG_ST_START 3'h1
`define SCFG_ST_BIT 3'h2
`define SCFG_ST_ACK 3'h3
`define SCFG_ST_DONE 3'h4
`define SCFG_ST_FAIL 3'h5
`endif

// ### scfg_strap_config.v
// Strap capture at reset release and serial management port role selection
// Function
// R01 - Strap pins are pulled-down inputs in reset, normal outputs after release.
// R02 - Receive-error strap low limits frames to 1522/1518, high allows 1536.
// R03 - Port 4 carrier-sense strap: low forces half duplex, high full duplex.
// R04 - Port 4 collision strap: low leaves flow control unforced, high forces it.
// R05 - Switch MII rx bit3 strap low disables full-duplex flow control.
// R06 - Switch MII rx bit2 strap low gives full duplex, high half duplex.
// R07 - LED one strap high enables fifth MII; low tristates its outputs.
// R08 - LED two strap high enables aging; low disables it.
// R09 - Role straps: 00 I2C master, 01 reserved, 10 SPI slave, 11 BIST.
// R10 - No EEPROM answer in I2C mode means start with default configuration.
// R11 - CPU drives SPI clock into device at 5 MHz or less.
// R12 - In I2C master mode the device drives the clock pin at 81 kHz.
// R13 - While SPI select is high the read output stays tristated.
// R14 - A transfer starts only on the falling edge of SPI select.
// R15 - Data pin is input in SPI mode, bidirectional in I2C mode.
// R16 - Read output and select are used only in SPI slave mode.
// R17 - Fifth MII rx bit0 strap high enables aggressive back-off.
// R18 - Fifth MII rx bit1 strap high keeps excessive-collision packets.
// R19 - Fifth MII rx bit2 strap high enables half-duplex back pressure.
// R20 - Fifth MII rx bit3 strap low enables flow control, high disables.
// R21 - All straps captured at reset release and held until next reset.
`include "strap_cfg_defs.vh"
`timescale 1ns/1ps
`default_nettype none
module scfg_strap_config (
  input wire core_clk,
  input wire rst,
  input wire p5_rx_error_strap,
  input wire p5_carrier_sense_strap,
  input wire p5_collision_strap,
  input wire sw_rx_bit3_strap,
  input wire sw_rx_bit2_strap,
  input wire p5_led_one_strap,
  input wire p5_led_two_strap,
  input wire serial_role_sel_hi,
  input wire serial_role_sel_lo,
  input wire p5_rx_bit0_strap,
  input wire p5_rx_bit1_strap,
  input wire p5_rx_bit2_strap,
  input wire p5_rx_bit3_strap,
  input wire spiReadBit,
  input wire serial_clock_pin_in,
  input wire serial_data_pin_in,
  input wire serial_select_n,
  output reg strapPinsDrive,
  output reg largeFrameEn,
  output reg port4FullDuplex,
  output reg port4ForceFlowCtrl,
  output reg swFlowCtrlEn,
  output reg swHalfDuplex,
  output reg p5MiiEnable,
  output reg agingEn,
  output reg aggrBackoffEn,
  output reg keepExcessCollision,
  output reg backPressureEn,
  output reg p5FlowCtrlEn,
  output reg [1:0] serialRole,
  output reg bistMode,
  output reg useDefaultConfig,
  output reg eepromDone,
  output reg serial_clock_pin_out,
  output reg serial_clock_pin_oe,
  output reg serial_data_pin_out,
  output reg serial_data_pin_oe,
  output reg serial_read_out,
  output reg serial_read_out_oe,
  output reg spiStart,
  output reg spiClkRise,
  output reg spiDataIn
);
  // Straps pass two flops; the last synchronised value is what reset release keeps
  reg [13:0] strapMeta;
  reg [13:0] strapSync;
  reg [2:0] spiMeta;
  reg [2:0] spiSync;
  reg selPrev;
  reg clkPrev;
  reg sdaMeta;
  reg sdaSync;
  reg rstPrev;
  reg [7:0] halfCnt;
  reg sclPhase;
  reg [2:0] state;
  reg [3:0] bitCnt;
  reg [15:0] waitCnt;
  wire [13:0] strapRaw;
  wire releaseEdge;
  wire tick;
  // Reload is one less than the half period so that a half period is exactly that many cycles
  localparam integer HALF_INT = `SCFG_I2C_HALF - 1;
  localparam [7:0] HALF_RELOAD = HALF_INT[7:0];
  localparam [7:0] EE_ADDR = `SCFG_EE_ADDR;

  assign strapRaw = {p5_rx_error_strap, p5_carrier_sense_strap, p5_collision_strap,
    sw_rx_bit3_strap, sw_rx_bit2_strap, p5_led_one_strap, p5_led_two_strap,
    serial_role_sel_hi, serial_role_sel_lo, p5_rx_bit0_strap, p5_rx_bit1_strap,
    p5_rx_bit2_strap, p5_rx_bit3_strap, 1'b0};
  assign releaseEdge = rstPrev & ~rst;
  assign tick = (halfCnt == 8'h00);

  ////////////////////////////////////////////////////////////////////////
  always @(posedge core_clk) begin
    strapMeta <= strapRaw;
    strapSync <= strapMeta;
    spiMeta <= {serial_select_n, serial_clock_pin_in, serial_data_pin_in};
    spiSync <= spiMeta;
    sdaMeta <= serial_data_pin_in;
    sdaSync <= sdaMeta;
    rstPrev <= rst;
  end

  ////////////////////////////////////////////////////////////////////////
  always @(posedge core_clk) begin
    if (rst) begin
      strapPinsDrive <= 1'b0; // [R01]
      largeFrameEn <= 1'b0;
      port4FullDuplex <= 1'b0;
      port4ForceFlowCtrl <= 1'b0;
      swFlowCtrlEn <= 1'b0;
      swHalfDuplex <= 1'b0;
      p5MiiEnable <= 1'b1;
      agingEn <= 1'b1;
      aggrBackoffEn <= 1'b0;
      keepExcessCollision <= 1'b0;
      backPressureEn <= 1'b0;
      p5FlowCtrlEn <= 1'b1;
      serialRole <= `SCFG_ROLE_I2C;
      bistMode <= 1'b0;
    end else begin
      strapPinsDrive <= 1'b1; // [R01]
      if (releaseEdge) begin // [R21]
        largeFrameEn <= strapSync[13]; // [R02]
        port4FullDuplex <= strapSync[12]; // [R03]
        port4ForceFlowCtrl <= strapSync[11]; // [R04]
        swFlowCtrlEn <= strapSync[10]; // [R05]
        swHalfDuplex <= strapSync[9]; // [R06]
        p5MiiEnable <= strapSync[8]; // [R07]
        agingEn <= strapSync[7]; // [R08]
        serialRole <= strapSync[6:5]; // [R09]
        bistMode <= (strapSync[6:5] == `SCFG_ROLE_BIST); // [R09]
        aggrBackoffEn <= strapSync[4]; // [R17]
        keepExcessCollision <= strapSync[3]; // [R18]
        backPressureEn <= strapSync[2]; // [R19]
        p5FlowCtrlEn <= ~strapSync[1]; // [R20]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // SPI slave front end; clock rate limit is the CPU's duty [R11]
  always @(posedge core_clk) begin
    if (rst) begin
      selPrev <= 1'b1;
      clkPrev <= 1'b0;
      spiStart <= 1'b0;
      spiClkRise <= 1'b0;
      spiDataIn <= 1'b0;
      serial_read_out <= 1'b0;
      serial_read_out_oe <= 1'b0;
    end else begin
      selPrev <= spiSync[2];
      clkPrev <= spiSync[1];
      spiStart <= (serialRole == `SCFG_ROLE_SPI) & selPrev & ~spiSync[2]; // [R14]
      spiClkRise <= (serialRole == `SCFG_ROLE_SPI) & ~spiSync[2] & ~clkPrev & spiSync[1];
      spiDataIn <= spiSync[0]; // [R15]
      serial_read_out <= spiReadBit;
      serial_read_out_oe <= (serialRole == `SCFG_ROLE_SPI) & ~spiSync[2]; // [R13] [R16]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // I2C probe: start, address byte, sample ack; no ack or timeout -> defaults
  always @(posedge core_clk) begin
    if (rst) begin
      halfCnt <= 8'h00;
      sclPhase <= 1'b1;
      state <= `SCFG_ST_IDLE;
      bitCnt <= 4'h0;
      waitCnt <= 16'h0000;
      serial_clock_pin_out <= 1'b1;
      serial_clock_pin_oe <= 1'b0;
      serial_data_pin_out <= 1'b1;
      serial_data_pin_oe <= 1'b0;
      useDefaultConfig <= 1'b0;
      eepromDone <= 1'b0;
    end else begin
      halfCnt <= tick ? HALF_RELOAD : (halfCnt - 8'h01); // [R12]
      serial_clock_pin_oe <= (serialRole == `SCFG_ROLE_I2C) & ~rstPrev; // [R12]
      // Clock holds high through the start so data can fall while it is high
      if (tick && state != `SCFG_ST_IDLE && state != `SCFG_ST_START
          && state != `SCFG_ST_DONE && state != `SCFG_ST_FAIL) begin
        sclPhase <= ~sclPhase;
        serial_clock_pin_out <= ~sclPhase;
      end
      if (state != `SCFG_ST_IDLE)
        waitCnt <= waitCnt + 16'h0001;
      case (state)
        `SCFG_ST_IDLE: begin
          if (releaseEdge && strapSync[6:5] == `SCFG_ROLE_I2C) begin
            state <= `SCFG_ST_START;
            serial_data_pin_oe <= 1'b1; // [R15]
            serial_data_pin_out <= 1'b1;
          end
        end
        `SCFG_ST_START: begin
          if (tick) begin
            serial_data_pin_out <= 1'b0;
            bitCnt <= 4'h7;
            state <= `SCFG_ST_BIT;
          end
        end
        `SCFG_ST_BIT: begin
          // Data moves only as the clock falls, never while it is high
          if (tick && sclPhase) begin
            serial_data_pin_out <= EE_ADDR[bitCnt[2:0]];
            if (bitCnt == 4'h0)
              state <= `SCFG_ST_ACK;
            else
              bitCnt <= bitCnt - 4'h1;
          end
        end
        `SCFG_ST_ACK: begin
          if (tick && sclPhase)
            serial_data_pin_oe <= 1'b0;
          if (tick && !sclPhase && !serial_data_pin_oe) begin
            state <= sdaSync ? `SCFG_ST_FAIL : `SCFG_ST_DONE; // [R10]
          end else if (waitCnt == `SCFG_TO_CYC) begin
            state <= `SCFG_ST_FAIL;
          end
        end
        `SCFG_ST_DONE: begin
          eepromDone <= 1'b1;
          serial_data_pin_oe <= 1'b0;
        end
        `SCFG_ST_FAIL: begin
          useDefaultConfig <= 1'b1; // [R10]
          serial_data_pin_oe <= 1'b0;
        end
        default: state <= `SCFG_ST_IDLE;
      endcase
    end
  end
endmodule // scfg_strap_config
`default_nettype wire

// ### scfg_strap_assertions.sv
// Checker for strap capture and serial role selection
`timescale 1ns/1ps
`default_nettype none
module scfg_strap_checker (
  input wire core_clk,
  input wire rst,
  input wire p5_rx_error_strap,
  input wire p5_led_two_strap,
  input wire p5_rx_bit3_strap,
  input wire serial_role_sel_hi,
  input wire serial_role_sel_lo,
  input wire serial_select_n,
  input wire largeFrameEn,
  input wire agingEn,
  input wire p5FlowCtrlEn,
  input wire [1:0] serialRole,
  input wire bistMode,
  input wire useDefaultConfig,
  input wire eepromDone,
  input wire serial_clock_pin_oe,
  input wire serial_data_pin_oe,
  input wire serial_read_out_oe,
  input wire spiStart
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  wire [4:0] cfg = {largeFrameEn, agingEn, p5FlowCtrlEn, serialRole};
  chk_cfg_hold: assert property (!$past(rst) && !$past(rst, 2) && !$past(rst, 3) |-> $stable(cfg))
    else $error("config moved after capture");
  chk_cfg_capture: assert property ($fell(rst) |-> ##1 cfg == {p5_rx_error_strap,
    p5_led_two_strap, !p5_rx_bit3_strap, serial_role_sel_hi, serial_role_sel_lo})
    else $error("captured config wrong");
  chk_spi_quiet: assert property (serial_select_n [*6] |-> !serial_read_out_oe)
    else $error("read output driven while deselected");
  chk_role_idle: assert property (serialRole != 2'h2 |-> !serial_read_out_oe && !spiStart)
    else $error("spi activity outside spi role");
  chk_i2c_pins: assert property (serialRole != 2'h0 |-> !serial_clock_pin_oe && !serial_data_pin_oe)
    else $error("clock or data pin driven outside i2c role");
  chk_bist_flag: assert property (bistMode == (serialRole == 2'h3))
    else $error("self test flag disagrees with role");
  chk_spi_start: assert property ($fell(serial_select_n) && serialRole == 2'h2 |-> ##[1:6] spiStart)
    else $error("no transfer start after select fall");
  chk_probe_end: assert property (useDefaultConfig |-> !eepromDone && serialRole == 2'h0)
    else $error("default start flag inconsistent");
  cover property (spiStart);
  cover property (useDefaultConfig);
  cover property (eepromDone);
endmodule // scfg_strap_checker
bind scfg_strap_config scfg_strap_checker chk (.*);
`default_nettype wire

// ### scfg_eeprom_model.sv
// Serial EEPROM stand-in that acknowledges its address byte
`timescale 1ns/1ps
`default_nettype none
module scfg_eeprom_model (
  input wire scl,
  input wire sda,
  input wire present,
  output logic ackLow
);
  int bits = 0;
  initial ackLow = 1'b0;
  always @(negedge sda) if (scl) bits = 0;
  always @(posedge scl) bits = bits + 1;
  // Absent device never pulls, so the line floats to its pull-up
  always @(negedge scl) ackLow = present && bits == 8;
endmodule // scfg_eeprom_model
`default_nettype wire

// ### test_scfg_strap_config.sv
// Self-checking bench for strap capture and serial role selection
`timescale 1ns/1ps
`default_nettype none
module test_scfg_strap_config;
  logic core_clk = 0, rst = 1, selN = 1, spiClk = 0, eePresent = 0, rdBit = 0;
  wire bist, rdOut, sdi;
  logic [12:0] straps = 13'h0000;
  int n_fail = 0, n_checks = 0, t = 0, rises = 0;
  wire ackLow, sclOut, sclOe, sdaOut, sdaOe, rdOe, spiStart, spiClkRise, drive, dflt, done;
  wire [12:0] cfg;
  wire scl = sclOe ? sclOut : (cfg[1:0] == 2'h2 ? spiClk : 1'b1);
  wire sda = ((sdaOe && !sdaOut) || ackLow) ? 1'b0 : 1'b1;
  logic [25:0] rows [4] = '{{13'h0000, 13'h0004}, {13'h1fff, 13'h1ffb},
    {13'h0aaa, 13'h0aae}, {13'h1555, 13'h1551}};
  scfg_strap_config uut (.core_clk, .rst, .p5_rx_error_strap(straps[12]),
    .p5_carrier_sense_strap(straps[11]), .p5_collision_strap(straps[10]),
    .sw_rx_bit3_strap(straps[9]), .sw_rx_bit2_strap(straps[8]), .p5_led_one_strap(straps[7]),
    .p5_led_two_strap(straps[6]), .p5_rx_bit0_strap(straps[5]), .p5_rx_bit1_strap(straps[4]),
    .p5_rx_bit2_strap(straps[3]), .p5_rx_bit3_strap(straps[2]), .serial_role_sel_hi(straps[1]),
    .serial_role_sel_lo(straps[0]), .serial_clock_pin_in(scl),
    .serial_data_pin_in(sda), .serial_select_n(selN), .strapPinsDrive(drive),
    .spiReadBit(rdBit),
    .largeFrameEn(cfg[12]), .port4FullDuplex(cfg[11]), .port4ForceFlowCtrl(cfg[10]),
    .swFlowCtrlEn(cfg[9]), .swHalfDuplex(cfg[8]), .p5MiiEnable(cfg[7]), .agingEn(cfg[6]),
    .aggrBackoffEn(cfg[5]), .keepExcessCollision(cfg[4]), .backPressureEn(cfg[3]),
    .p5FlowCtrlEn(cfg[2]), .serialRole(cfg[1:0]), .bistMode(bist), .useDefaultConfig(dflt),
    .eepromDone(done), .serial_clock_pin_out(sclOut), .serial_clock_pin_oe(sclOe),
    .serial_data_pin_out(sdaOut), .serial_data_pin_oe(sdaOe), .serial_read_out(rdOut),
    .serial_read_out_oe(rdOe), .spiStart(spiStart), .spiClkRise(spiClkRise), .spiDataIn(sdi));
  scfg_eeprom_model eeprom (.scl(scl), .sda(sda), .present(eePresent), .ackLow(ackLow));
  always #12.5 core_clk = ~core_clk;
  always @(posedge core_clk) if (spiClkRise === 1'b1) rises++;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #2;
  endtask
  task automatic check(input string what, input logic [12:0] exp, input logic [12:0] got);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic boot(input logic [12:0] s);
    rst = 1;
    straps = s;
    tick(20);
    rst = 0;
    tick(3);
  endtask
  task automatic wait_scl(input logic v);
    t = 0;
    while (sclOut !== v && t < 999) begin
      tick(1);
      t++;
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    #1_000_000;
    n_fail++;
    report_and_stop;
  end
  initial begin
    tick(20);
    check("reset state", 13'h00c4, cfg);
    check("reset pins", 13'h0000, {9'h000, drive, rdOe, sclOe, sdaOe});
    for (int i = 0; i < 4; i++) begin
      boot(rows[i][25:13]);
      check("captured", rows[i][12:0], cfg);
      check("pins drive", 13'h0001, {12'h000, drive});
      check("bist", {12'h000, rows[i][1:0] == 2'h3}, {12'h000, bist});
      straps = ~straps;
      tick(8);
      check("held", rows[i][12:0], cfg);
      $display("strap row %0d done", i);
    end
    boot(13'h0002);
    tick(6);
    check("deselected oe", 13'h0000, {12'h000, rdOe});
    selN = 0;
    rdBit = 1;
    t = 0;
    while (spiStart !== 1'b1 && t < 8) begin
      tick(1);
      t++;
    end
    check("start and oe", 13'h0003, {11'h000, t < 8, rdOe});
    check("read bit and data", 13'h0003, {11'h000, rdOut, sdi});
    rises = 0;
    // Clock only inside the frame, 5 MHz like a slow host
    repeat (3) begin
      spiClk = 1;
      #100 spiClk = 0;
      #100;
    end
    tick(6);
    check("clock rises", 13'h0003, rises[12:0]);
    selN = 1;
    tick(8);
    check("released oe", 13'h0000, {12'h000, rdOe});
    $display("spi test done");
    for (int p = 0; p < 2; p++) begin
      eePresent = p[0];
      boot(13'h0000);
      wait_scl(1'b0);
      wait_scl(1'b1);
      wait_scl(1'b0);
      check("scl half", 13'h0001, {12'h000, t >= 245 && t <= 247});
      t = 0;
      while (dflt !== 1'b1 && done !== 1'b1 && t < 20000) begin
        tick(1);
        t++;
      end
      check("probe result", {11'h000, p[0], !p[0]}, {11'h000, done, dflt});
      $display("probe test %0d done", p);
    end
    report_and_stop;
  end
endmodule // test_scfg_strap_config
`default_nettype wire
